//--- bench/ddr3c_ctrl_model.sv
module ddr3c_ctrl_model (
  input wire logic clock,
  input wire logic run,
  output logic ck,
  output ddr3c_pkg::ddr3c_cmdpins_s cmdPins
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddr3c_pkg::*;

  logic [1:0] phase;

  // link clock idle low and deselected until run
  initial begin
    phase = 2'h0;
    ck = 1'b0;
    cmdPins = '1;
  end

  // link clock of 8 system clocks a period
  always @(posedge clock) begin
    if (run) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        ck <= ~ck;
      end
    end
  end

  // pins set at a fall, held through the rise, then deselect with toggled lines
  task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic [14:0] a);
    @(posedge clock iff (run && phase == 2'h3 && ck));
    cmdPins <= {1'b0, rcw, ba, a};
    @(posedge clock iff (run && phase == 2'h3 && ck));
    cmdPins <= {1'b1, 3'h7, ~ba, ~a};
  endtask
endmodule // ddr3c_ctrl_model

//--- bench/test_ddr3c_top.sv
module test_ddr3c_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ddr3c_pkg::*;

  localparam int TRP = 20;
  localparam int RL = 5;
  localparam logic [2:0] MRS = 3'h0;
  localparam logic [2:0] ACT = 3'h3;
  localparam logic [2:0] PRE = 3'h2;
  localparam logic [2:0] RD = 3'h5;
  localparam logic [2:0] WR = 3'h4;
  localparam logic [14:0] SRA[3] = '{15'h0000, 15'h0080, 15'h0040};
  localparam ddr3c_sr_e SRE[3] = '{SR_NORMAL, SR_EXTENDED, SR_AUTO};

  logic clock;
  logic rst_b;
  logic ck;
  logic run;
  ddr3c_cmdpins_s cmdPins;
  ddr3c_regbus_s regBus;
  logic [31:0] rdData;
  logic [7:0] dq;
  logic dqOe;
  ddr3c_sr_e srMode;
  ddr3c_arrayreq_s arrayReq;
  ddr3c_arrayreq_s lastReq;
  int failures;
  int total_checks;
  int reqCount;
  int ckRises;
  int oeAt;
  int cmdAt;
  logic [7:0] beats[$];

  ddr3c_top #(.TRP_CYCLES(TRP)) ddr3c_top_inst (.clock(clock), .rst_b(rst_b), .ck(ck),
    .cmdPins(cmdPins), .regBus(regBus), .rdData(rdData), .dq(dq), .dqOe(dqOe),
    .srMode(srMode), .arrayReq(arrayReq));
  ddr3c_ctrl_model ddr3c_ctrl_model_inst (.clock(clock), .run(run), .ck(ck),
    .cmdPins(cmdPins));

  // 40 MHz system clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // link edges, burst start and output capture
  always @(posedge ck) ckRises++;
  always @(posedge dqOe) oeAt = ckRises;
  always @(posedge clock) begin
    if (dqOe === 1'b1) beats.push_back(dq);
    if (arrayReq.valid === 1'b1) begin
      reqCount++;
      lastReq = arrayReq;
    end
  end

  task automatic print_verdict();
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regBus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    regBus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic expReg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clock);
    regBus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    regBus.rd <= 1'b0;
    #1;
    check(rdData & m, e);
  endtask

  // one link command, then let state settle
  task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba, input logic [14:0] a);
    ddr3c_ctrl_model_inst.issue(rcw, ba, a);
    repeat (8) @(posedge clock);
  endtask

  // pattern read with junk bank bits; one beat is 4 system clocks
  task automatic burst(input logic [14:0] a, input int n, input int first, input logic cp);
    logic b;
    beats.delete();
    ddr3c_ctrl_model_inst.issue(RD, 3'h7, a);
    cmdAt = ckRises;
    repeat ((RL + 6) * 8) @(posedge clock);
    check(32'(oeAt - cmdAt), 32'(RL));
    check(32'(beats.size()), 32'(n * 4));
    for (int k = 0; k < n; k++) begin
      b = PATTERN_LOC0[first + k];
      check(32'(beats[4 * k + 2]), cp ? {24'h0, {8{b}}} : {31'h0, b});
    end
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    print_verdict();
  end

  initial begin
    rst_b = 1'b0;
    run = 1'b0;
    regBus = '0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    // reset values, unmapped place
    expReg(REG_CTRL, 32'h15, '1);
    expReg(REG_STATUS, 32'h0, '1);
    expReg(REG_BANKS, 32'h0, '1);
    regWrite(4'hc, 32'hffff_ffff);
    expReg(4'hc, 32'h0, '1);
    run <= 1'b1;
    // self-refresh settings, A7 kept low with A6 set
    for (int i = 0; i < 3; i++) begin
      cmd(MRS, 3'h2, SRA[i]);
      check(32'(srMode), 32'(SRE[i]));
      expReg(REG_STATUS, {30'h0, SRE[i]}, '1);
    end
    // array traffic, auto-precharge on one bank beside access to another
    cmd(ACT, 3'h3, 15'h1234);
    cmd(ACT, 3'h4, 15'h0042);
    expReg(REG_BANKS, 32'h18, 32'hff);
    ddr3c_ctrl_model_inst.issue(RD, 3'h3, 15'h0408);
    cmd(WR, 3'h4, 15'h0010);
    check(32'(reqCount), 32'h2);
    check(32'(lastReq), {17'h0, 1'b1, 1'b1, 3'h4, 10'h010});
    cmd(PRE, 3'h0, 15'h0400);
    expReg(REG_BANKS, 32'h0, 32'hff);
    // activation inside the precharge period is refused
    cmd(ACT, 3'h5, 15'h0001);
    ddr3c_ctrl_model_inst.issue(PRE, 3'h5, 15'h0);
    cmd(ACT, 3'h5, 15'h0002);
    expReg(REG_BANKS, 32'h0, 32'hff);
    expReg(REG_STATUS, 32'h20, 32'h20);
    regWrite(REG_STATUS, 32'h20);
    expReg(REG_STATUS, 32'h0, 32'h20);
    // second precharge to an idle bank restarts the period
    cmd(PRE, 3'h6, 15'h0);
    ddr3c_ctrl_model_inst.issue(PRE, 3'h6, 15'h0);
    cmd(ACT, 3'h6, 15'h0003);
    expReg(REG_STATUS, 32'h20, 32'h20);
    repeat (24) @(posedge clock);
    cmd(ACT, 3'h6, 15'h0003);
    expReg(REG_BANKS, 32'h40, 32'hff);
    // pattern reads, column A1:A0 zero and location 00
    cmd(MRS, 3'h3, 15'h0004);
    expReg(REG_STATUS, 32'h04, 32'h1c);
    burst(15'h2bf8, 8, 0, 1'b1);
    regWrite(REG_CTRL, 32'h05);
    cmd(MRS, 3'h0, 15'h0002);
    burst(15'h0004, 4, 4, 1'b0);
    cmd(MRS, 3'h0, 15'h0001);
    burst(15'h0000, 4, 0, 1'b0);
    burst(15'h1000, 8, 0, 1'b0);
    cmd(WR, 3'h6, 15'h0010);
    check(32'(reqCount), 32'h2);
    for (int l = 1; l < 4; l++) begin
      cmd(MRS, 3'h3, 15'(4 + l));
      expReg(REG_STATUS, 32'(4 + 8 * l), 32'h1c);
    end
    // back to the array
    cmd(MRS, 3'h3, 15'h0000);
    cmd(RD, 3'h6, 15'h0020);
    check(32'(reqCount), 32'h3);
    check(32'(lastReq), {17'h0, 1'b1, 1'b0, 3'h6, 10'h020});
    print_verdict();
  end
endmodule // test_ddr3c_top

//--- design/ddr3c_bank_table.sv
module ddr3c_bank_table #(
  parameter int TRP_CYCLES = ddr3c_pkg::TRP_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic act,
  input wire logic pre,
  input wire logic preAll,
  input wire logic [2:0] bank,
  input wire logic [14:0] row,
  output logic [7:0] openMask,
  output logic [7:0] preMask
);
  import ddr3c_pkg::*;

  localparam int CW = $clog2(TRP_CYCLES + 1);

  typedef struct packed {
    logic [NUM_BANKS-1:0] open;
    logic [NUM_BANKS-1:0] pre;
    logic [NUM_BANKS-1:0][CW-1:0] cnt;
    logic [NUM_BANKS-1:0][14:0] row;
  } ddr3c_bank_state_s;

  ddr3c_bank_state_s s;
  ddr3c_bank_state_s next_s;

  // precharge timers, activation and precharge per bank
  always_comb begin
    next_s = s;
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (s.pre[i]) begin
        if (s.cnt[i] <= CW'(1)) begin
          next_s.pre[i] = 1'b0;
          next_s.cnt[i] = '0;
        end else begin
          next_s.cnt[i] = s.cnt[i] - CW'(1);
        end
      end
    end
    if (act && !s.pre[bank]) begin
      next_s.open[bank] = 1'b1;
      next_s.row[bank] = row;
    end
    if (pre) begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        if (preAll || bank == 3'(i)) begin
          next_s.open[i] = 1'b0;
          next_s.pre[i] = 1'b1;
          next_s.cnt[i] = CW'(TRP_CYCLES);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign openMask = s.open;
  assign preMask = s.pre;

  a_act_opens: assert property (@(posedge clock) disable iff (!rst_b)
    act && !pre && !s.pre[bank] |=> s.open[$past(bank)])
    else $error("activation did not open the bank");

  a_pre_all: assert property (@(posedge clock) disable iff (!rst_b)
    pre && preAll |=> s.open == 8'h00 && s.pre == 8'hff)
    else $error("precharge all left a bank open");

  a_pre_blocks: assert property (@(posedge clock) disable iff (!rst_b)
    pre && !preAll |=> s.pre[$past(bank)] && !s.open[$past(bank)])
    else $error("precharged bank not held busy");

endmodule // ddr3c_bank_table

//--- design/ddr3c_pattern_gen.sv
module ddr3c_pattern_gen #(
  parameter logic [7:0] LOC1_WORD = 8'h00,
  parameter logic [7:0] LOC2_WORD = 8'h00,
  parameter logic [7:0] LOC3_WORD = 8'h00
) (
  input wire logic [1:0] loc,
  input wire logic [2:0] beatIdx,
  output logic beatBit
);
  import ddr3c_pkg::*;

  logic [7:0] word;

  // pick the location word, beat index selects the bit
  always_comb begin
    case (loc)
      2'h0: word = PATTERN_LOC0;
      2'h1: word = LOC1_WORD;
      2'h2: word = LOC2_WORD;
      2'h3: word = LOC3_WORD;
      default: word = 8'h00;
    endcase
    beatBit = word[beatIdx];
  end

endmodule // ddr3c_pattern_gen

//--- design/ddr3c_top.sv
module ddr3c_top #(
  parameter int TRP_CYCLES = ddr3c_pkg::TRP_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ck,
  input wire ddr3c_pkg::ddr3c_cmdpins_s cmdPins,
  input wire ddr3c_pkg::ddr3c_regbus_s regBus,
  output logic [31:0] rdData,
  output logic [7:0] dq,
  output logic dqOe,
  output ddr3c_pkg::ddr3c_sr_e srMode,
  output ddr3c_pkg::ddr3c_arrayreq_s arrayReq
);
  import ddr3c_pkg::*;

  typedef struct packed {
    logic [1:0] ckSync;
    logic ckPrev;
    ddr3c_cmdpins_s pinSync1;
    ddr3c_cmdpins_s pinSync2;
    logic [1:0] mr0Bl;
    logic mprEn;
    logic [1:0] mprLoc;
    logic [3:0] rl;
    logic copyAll;
    logic actErr;
    logic rdErr;
    logic readPending;
    logic [3:0] latCnt;
    logic [1:0] pendLoc;
    logic pendChop;
    logic [2:0] pendStart;
    logic burstActive;
    logic [1:0] burstLoc;
    logic chop;
    logic [2:0] curIdx;
    logic [2:0] beatsLeft;
    logic [31:0] rdData;
    logic [7:0] dq;
    logic dqOe;
    ddr3c_sr_e srMode;
    ddr3c_arrayreq_s arrayReq;
  } ddr3c_top_state_s;

  ddr3c_top_state_s s;
  ddr3c_top_state_s next_s;

  logic ckRise;
  logic ckEdge;
  ddr3c_cmd_e cmd;
  logic [14:0] cmdAddr;
  logic [2:0] cmdBank;
  logic burstStart;
  logic [2:0] patIdx;
  logic patBit;
  logic [7:0] openMask;
  logic [7:0] preMask;
  logic bankAct;
  logic bankPre;
  logic bankPreAll;
  logic mrsRefresh;
  logic mrsReadout;
  logic rdCmd;
  logic cmdChop;

  // edges of the sampled link clock and the command taken on its rise
  always_comb begin
    ckRise = s.ckSync[1] & ~s.ckPrev;
    ckEdge = s.ckSync[1] ^ s.ckPrev;
    cmd = ckRise ? cmd_decode(s.pinSync2) : CMD_NOP;
    cmdAddr = s.pinSync2.addr;
    cmdBank = s.pinSync2.ba;
    mrsRefresh = (cmd == CMD_MRS) && (cmdBank == MR_SEL_REFRESH);
    mrsReadout = (cmd == CMD_MRS) && (cmdBank == MR_SEL_READOUT);
    rdCmd = (cmd == CMD_READ);
    burstStart = ckRise && s.readPending && (s.latCnt <= 4'h1);
    patIdx = burstStart ? s.pendStart : s.curIdx + 3'h1;
  end

  // chop from fixed setting or from A12 when on-the-fly is chosen
  always_comb begin
    case (s.mr0Bl)
      BL_FIXED4: cmdChop = 1'b1;
      BL_OTF: cmdChop = ~cmdAddr[BC_BIT];
      default: cmdChop = 1'b0;
    endcase
  end

  // bank table requests; auto-precharge rides on array accesses only
  always_comb begin
    bankAct = (cmd == CMD_ACT);
    bankPre = (cmd == CMD_PRE) ||
              (((cmd == CMD_READ) || (cmd == CMD_WRITE)) && !s.mprEn && cmdAddr[AP_BIT]);
    bankPreAll = (cmd == CMD_PRE) && cmdAddr[AP_BIT];
  end

  ddr3c_bank_table #(
    .TRP_CYCLES(TRP_CYCLES)
  ) u_banks (
    .clock(clock),
    .rst_b(rst_b),
    .act(bankAct),
    .pre(bankPre),
    .preAll(bankPreAll),
    .bank(cmdBank),
    .row(cmdAddr),
    .openMask(openMask),
    .preMask(preMask)
  );

  ddr3c_pattern_gen u_pattern (
    .loc(burstStart ? s.pendLoc : s.burstLoc),
    .beatIdx(patIdx),
    .beatBit(patBit)
  );

  // next state: bus slave, mode registers, commands, read burst
  always_comb begin
    next_s = s;
    next_s.ckSync = {s.ckSync[0], ck};
    next_s.ckPrev = s.ckSync[1];
    next_s.pinSync1 = cmdPins;
    next_s.pinSync2 = s.pinSync1;
    next_s.arrayReq = '0;
    next_s.rdData = 32'h0;

    // register reads, data in the following cycle only
    if (regBus.rd) begin
      case (regBus.addr)
        REG_CTRL: begin
          next_s.rdData[CTRL_RL_LSB +: 4] = s.rl;
          next_s.rdData[CTRL_COPY_BIT] = s.copyAll;
        end
        REG_STATUS: begin
          next_s.rdData[ST_SR_LSB +: 2] = s.srMode;
          next_s.rdData[ST_MPREN_BIT] = s.mprEn;
          next_s.rdData[ST_MPRLOC_LSB +: 2] = s.mprLoc;
          next_s.rdData[ST_ACTERR_BIT] = s.actErr;
          next_s.rdData[ST_RDERR_BIT] = s.rdErr;
          next_s.rdData[ST_BL_LSB +: 2] = s.mr0Bl;
        end
        REG_BANKS: begin
          next_s.rdData[BK_OPEN_LSB +: 8] = openMask;
          next_s.rdData[BK_PRE_LSB +: 8] = preMask;
        end
        default: next_s.rdData = 32'h0;
      endcase
    end

    // register writes; error flags clear by writing one
    if (regBus.wr) begin
      case (regBus.addr)
        REG_CTRL: begin
          next_s.rl = (regBus.wdata[CTRL_RL_LSB +: 4] == 4'h0) ? 4'h1 :
                      regBus.wdata[CTRL_RL_LSB +: 4];
          next_s.copyAll = regBus.wdata[CTRL_COPY_BIT];
        end
        REG_STATUS: begin
          if (regBus.wdata[ST_ACTERR_BIT]) next_s.actErr = 1'b0;
          if (regBus.wdata[ST_RDERR_BIT]) next_s.rdErr = 1'b0;
        end
        default: next_s.rl = next_s.rl;
      endcase
    end

    // commands on a link clock rise; a set here wins over the clear above
    case (cmd)
      CMD_MRS: begin
        if (cmdBank == MR_SEL_BURST) next_s.mr0Bl = cmdAddr[BL_LSB +: 2];
        if (mrsRefresh) begin
          case ({cmdAddr[ASR_BIT], cmdAddr[SRT_BIT]})
            2'h0: next_s.srMode = SR_NORMAL;
            2'h1: next_s.srMode = SR_EXTENDED;
            2'h2: next_s.srMode = SR_AUTO;
            default: next_s.srMode = SR_ILLEGAL;
          endcase
        end
        if (mrsReadout) begin
          next_s.mprEn = cmdAddr[MPR_EN_BIT];
          next_s.mprLoc = cmdAddr[MPR_LOC_LSB +: 2];
        end
      end
      CMD_ACT: begin
        if (preMask[cmdBank]) next_s.actErr = 1'b1;
      end
      CMD_READ, CMD_WRITE: begin
        if (s.mprEn) begin
          // bank and upper column bits take no part here
          if (rdCmd) begin
            next_s.readPending = 1'b1;
            next_s.latCnt = s.rl;
            next_s.pendLoc = s.mprLoc;
            next_s.pendChop = cmdChop;
            next_s.pendStart = cmdChop ? {cmdAddr[NIBBLE_BIT], 2'h0} : 3'h0;
            if (cmdAddr[1:0] != 2'h0) next_s.rdErr = 1'b1;
          end
        end else begin
          next_s.arrayReq.valid = 1'b1;
          next_s.arrayReq.write = (cmd == CMD_WRITE);
          next_s.arrayReq.bank = cmdBank;
          next_s.arrayReq.col = cmdAddr[9:0];
          if (!openMask[cmdBank]) next_s.rdErr = 1'b1;
        end
      end
      default: next_s.latCnt = next_s.latCnt;
    endcase

    // latency count and beat stream, one beat per link clock edge
    if (burstStart) begin
      next_s.readPending = 1'b0;
      next_s.burstActive = 1'b1;
      next_s.burstLoc = s.pendLoc;
      next_s.chop = s.pendChop;
      next_s.curIdx = patIdx;
      next_s.beatsLeft = s.pendChop ? 3'h3 : 3'h7;
      next_s.dq = {(s.copyAll ? {7{patBit}} : 7'h00), patBit};
      next_s.dqOe = 1'b1;
    end else begin
      if (ckRise && s.readPending) next_s.latCnt = s.latCnt - 4'h1;
      if (ckEdge && s.burstActive) begin
        if (s.beatsLeft != 3'h0) begin
          next_s.curIdx = patIdx;
          next_s.beatsLeft = s.beatsLeft - 3'h1;
          next_s.dq = {(s.copyAll ? {7{patBit}} : 7'h00), patBit};
        end else begin
          next_s.burstActive = 1'b0;
          next_s.dqOe = 1'b0;
          next_s.dq = 8'h00;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
      s.rl <= CTRL_RL_RST;
      s.copyAll <= CTRL_COPY_RST;
      s.srMode <= SR_NORMAL;
    end else begin
      s <= next_s;
    end
  end

  assign rdData = s.rdData;
  assign dq = s.dq;
  assign dqOe = s.dqOe;
  assign srMode = s.srMode;
  assign arrayReq = s.arrayReq;

  a_sr_normal: assert property (@(posedge clock) disable iff (!rst_b)
    mrsRefresh && !cmdAddr[ASR_BIT] && !cmdAddr[SRT_BIT] |=> srMode == SR_NORMAL)
    else $error("normal self-refresh rate not selected");

  a_sr_extended: assert property (@(posedge clock) disable iff (!rst_b)
    mrsRefresh && !cmdAddr[ASR_BIT] && cmdAddr[SRT_BIT] |=> srMode == SR_EXTENDED)
    else $error("extended self-refresh rate not selected");

  a_sr_auto: assert property (@(posedge clock) disable iff (!rst_b)
    mrsRefresh && cmdAddr[ASR_BIT] && !cmdAddr[SRT_BIT] |=> srMode == SR_AUTO)
    else $error("automatic self-refresh not selected");

  a_array_route: assert property (@(posedge clock) disable iff (!rst_b)
    rdCmd && !s.mprEn |=> arrayReq.valid && !arrayReq.write ##1 !arrayReq.valid)
    else $error("array read not passed on as one pulse");

  a_pattern_enter: assert property (@(posedge clock) disable iff (!rst_b)
    mrsReadout && cmdAddr[MPR_EN_BIT] |=> s.mprEn && s.mprLoc == $past(cmdAddr[1:0]))
    else $error("pattern mode not entered");

  a_dq_copy: assert property (@(posedge clock) disable iff (!rst_b)
    dqOe |-> (dq[7:1] == 7'h00) || (dq[7:1] == {7{dq[0]}}))
    else $error("upper data bits neither copy nor zero");

  a_pattern_noarray: assert property (@(posedge clock) disable iff (!rst_b)
    rdCmd && s.mprEn |=> !arrayReq.valid && s.readPending)
    else $error("pattern read reached the array");

  a_chop_length: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(dqOe) |-> s.beatsLeft == (s.chop ? 3'h3 : 3'h7))
    else $error("burst length does not match chop");

  a_loc0_pattern: assert property (@(posedge clock) disable iff (!rst_b)
    dqOe && s.burstLoc == 2'h0 |-> dq[0] == s.curIdx[0])
    else $error("calibration pattern not alternating");

endmodule // ddr3c_top

//--- shared/ddr3c_pkg.sv
package ddr3c_pkg;

  // clock and bank timing
  localparam int CLK_MHZ = 40;
  localparam int TRP_NS = 15;
  localparam int TRP_RAW = (TRP_NS * CLK_MHZ + 999) / 1000;
  localparam int TRP_CYC = (TRP_RAW < 1) ? 1 : TRP_RAW;
  localparam int NUM_BANKS = 8;

  // register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_BANKS = 4'h8;

  // control register fields and reset values
  localparam int CTRL_RL_LSB = 0;
  localparam int CTRL_COPY_BIT = 4;
  localparam logic [3:0] CTRL_RL_RST = 4'h5;
  localparam logic CTRL_COPY_RST = 1'b1;

  // status register fields
  localparam int ST_SR_LSB = 0;
  localparam int ST_MPREN_BIT = 2;
  localparam int ST_MPRLOC_LSB = 3;
  localparam int ST_ACTERR_BIT = 5;
  localparam int ST_RDERR_BIT = 6;
  localparam int ST_BL_LSB = 8;

  // bank register fields
  localparam int BK_OPEN_LSB = 0;
  localparam int BK_PRE_LSB = 8;

  // mode register selects on the bank pins
  localparam logic [2:0] MR_SEL_BURST = 3'h0;
  localparam logic [2:0] MR_SEL_REFRESH = 3'h2;
  localparam logic [2:0] MR_SEL_READOUT = 3'h3;

  // address bit positions
  localparam int ASR_BIT = 6;
  localparam int SRT_BIT = 7;
  localparam int MPR_EN_BIT = 2;
  localparam int MPR_LOC_LSB = 0;
  localparam int BL_LSB = 0;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int NIBBLE_BIT = 2;

  // burst length codes
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // calibration pattern, beat 0 in the lsb
  localparam logic [7:0] PATTERN_LOC0 = 8'haa;

  typedef enum logic [1:0] {SR_NORMAL, SR_EXTENDED, SR_AUTO, SR_ILLEGAL} ddr3c_sr_e;
  typedef enum logic [2:0] {CMD_NOP, CMD_MRS, CMD_ACT, CMD_PRE, CMD_READ, CMD_WRITE,
                            CMD_OTHER} ddr3c_cmd_e;

  typedef struct packed {
    logic csB;
    logic rasB;
    logic casB;
    logic weB;
    logic [2:0] ba;
    logic [14:0] addr;
  } ddr3c_cmdpins_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } ddr3c_regbus_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic [2:0] bank;
    logic [9:0] col;
  } ddr3c_arrayreq_s;

  // command from the sampled pin levels
  function automatic ddr3c_cmd_e cmd_decode(input ddr3c_cmdpins_s p);
    ddr3c_cmd_e c;
    c = CMD_OTHER;
    if (p.csB) begin
      c = CMD_NOP;
    end else begin
      case ({p.rasB, p.casB, p.weB})
        3'h0: c = CMD_MRS;
        3'h3: c = CMD_ACT;
        3'h2: c = CMD_PRE;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h7: c = CMD_NOP;
        default: c = CMD_OTHER;
      endcase
    end
    return c;
  endfunction

endpackage
